/* File: ztbs_pkg.sv */
// ztbs_pkg: shared constants for the burst sram port and its controller.
// assumes a single clock; no register map, all control travels on the pins.
package ztbs_pkg;
  localparam int ZTBS_ADDR_W = 17;
  localparam int ZTBS_DATA_W = 36;
  localparam int ZTBS_LANES = 4;
  localparam int ZTBS_LANE_W = 9;
  localparam int ZTBS_BURST_LEN = 4;
  localparam int ZTBS_BURST_W = 2;
  localparam logic ZTBS_ORDER_LINEAR = 1'b0;
  localparam logic ZTBS_ORDER_INTERLEAVED = 1'b1;
  typedef enum logic [2:0] {
    ZTBS_OP_IDLE = 3'b001,
    ZTBS_OP_READ = 3'b010,
    ZTBS_OP_WRITE = 3'b100
  } ztbs_op_type;
endpackage

/* File: ztbs_if.sv */
// ztbs_if: pins between the sram port and its controller.
// the interface resolves the shared data wire from the two enables, the sram side first.
`timescale 1ns/1ps
`default_nettype none
interface ztbs_if (
  input wire logic clk
);
  import ztbs_pkg::*;
  logic [ZTBS_ADDR_W-1:0] word_address;
  logic read_not_write;
  logic advance_or_load;
  logic cycle_enable_low;
  logic select_low_a;
  logic select_low_b;
  logic select_high;
  logic [ZTBS_LANES-1:0] byte_lane_write_n;
  logic output_drive_n;
  logic burst_order_select;
  logic [ZTBS_DATA_W-1:0] mem_data_out;
  logic mem_data_oe;
  logic [ZTBS_DATA_W-1:0] ctl_data_out;
  logic ctl_data_oe;
  logic [ZTBS_DATA_W-1:0] bus_data;
  assign bus_data = mem_data_oe ? mem_data_out : (ctl_data_oe ? ctl_data_out : '0);
  modport mem (
    input word_address, read_not_write, advance_or_load, cycle_enable_low,
    input select_low_a, select_low_b, select_high, byte_lane_write_n,
    input output_drive_n, burst_order_select, bus_data,
    output mem_data_out, mem_data_oe
  );
  modport ctl (
    output word_address, read_not_write, advance_or_load, cycle_enable_low,
    output select_low_a, select_low_b, select_high, byte_lane_write_n,
    output output_drive_n, burst_order_select, ctl_data_out, ctl_data_oe,
    input bus_data
  );
endinterface
`default_nettype wire

/* File: ztbs_mem.sv */
// ztbs_mem: the sram port, 128k x 36 array with registered inputs and
// flow-through reads. assumes the controller obeys the one-cycle data rhythm.
//
// Contract
// - data moves the cycle after its command
// - read data flows through, no output register
// - output enable acts without the clock
// - frozen state while cycle enable high
// - disabled edge leaves outputs as before
// - deselect stops burst, finishes pending transfer
// - bus floats one cycle after deselect/write
// - four beats from one loaded address
// - load low takes address, high advances
// - address captured only on selected load
// - advance ignores the address pins
// - read_not_write on load picks direction
// - controller drives lane enables every write beat
// - lane enables ignored on reads
// - lanes may be tied low for words
// - any select false with load deselects
// - array is 128k words of 36 bits
// - reads and writes mix back to back
// - order select high interleaved, low linear
// - output_drive_n high floats the pins
`timescale 1ns/1ps
`default_nettype none
module ztbs_mem
  import ztbs_pkg::*;
#(
  parameter int ADDR_W = ZTBS_ADDR_W,
  parameter int LANES = ZTBS_LANES,
  parameter int LANE_W = ZTBS_LANE_W
) (
  input wire logic clk_sys_in, // port clock
  input wire logic sys_rst_in, // async reset, high
  ztbs_if.mem pin_if // memory pins
);
  localparam int DATA_W = LANES * LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  // the burst counter owns the two low address bits, so the address must be wider
  if (ADDR_W <= ZTBS_BURST_W) begin : g_bad_addr
    $error("ztbs_mem: address too narrow for the burst counter");
  end
  // lanes must tile the shared data pins exactly
  if (DATA_W != ZTBS_DATA_W) begin : g_bad_width
    $error("ztbs_mem: lanes do not fill the data pins");
  end
  // lane enables arrive on a pin group of fixed size
  if (LANES != ZTBS_LANES) begin : g_bad_lanes
    $error("ztbs_mem: lane count differs from the pin group");
  end
  // the counter width must cover exactly one burst
  if ((1 << ZTBS_BURST_W) != ZTBS_BURST_LEN) begin : g_bad_burst
    $error("ztbs_mem: burst counter does not match the burst length");
  end

  // storage is never reset; only the control path starts clean
  logic [DATA_W-1:0] array_mem [DEPTH];
  logic [ADDR_W-1:0] base_reg;
  logic [ZTBS_BURST_W-1:0] beat_reg;
  logic burst_live_reg;
  ztbs_op_type burst_op_reg;
  ztbs_op_type pend_op_reg;
  logic [ADDR_W-1:0] pend_addr_reg;
  logic [LANES-1:0] pend_lane_n_reg;
  logic order_reg;

  logic enable;
  logic selected;
  logic load;
  logic sel_load;
  logic desel_load;
  logic adv;
  logic store_en;
  logic read_pend;
  logic drive_ok;
  ztbs_op_type load_op;
  logic [ZTBS_BURST_W-1:0] low_lin;
  logic [ZTBS_BURST_W-1:0] low_int;
  logic [ZTBS_BURST_W-1:0] low_next;
  logic [ZTBS_BURST_W-1:0] beat_next;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] wr_word;

  assign enable = ~pin_if.cycle_enable_low;
  // any one select false counts as deselect
  // a select only matters on a load; an advance ignores all three
  assign selected = ~pin_if.select_low_a & ~pin_if.select_low_b & pin_if.select_high;
  assign load = enable & ~pin_if.advance_or_load;
  assign sel_load = load & selected;
  assign desel_load = load & ~selected;
  // an advance with no live burst, e.g. after a deselect, starts nothing
  assign adv = enable & pin_if.advance_or_load & burst_live_reg;
  assign load_op = pin_if.read_not_write ? ZTBS_OP_READ : ZTBS_OP_WRITE;
  assign store_en = enable & (pend_op_reg == ZTBS_OP_WRITE);
  assign read_pend = (pend_op_reg == ZTBS_OP_READ);
  assign drive_ok = ~pin_if.output_drive_n;
  assign wr_word = pin_if.bus_data;
  assign beat_next = beat_reg + 2'd1;
  // only the two low bits move
  assign low_lin = base_reg[ZTBS_BURST_W-1:0] + beat_next;
  assign low_int = base_reg[ZTBS_BURST_W-1:0] ^ beat_next;
  assign low_next = (order_reg == ZTBS_ORDER_INTERLEAVED) ? low_int : low_lin;

  // order pin is static; sampled on each load so a change never splits a burst
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      order_reg <= ZTBS_ORDER_LINEAR;
    end else if (load) begin
      order_reg <= pin_if.burst_order_select;
    end
  end

  // address register: only a selected load opens it
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      base_reg <= '0;
    end else if (sel_load) begin
      base_reg <= pin_if.word_address;
    end
  end

  // beat counter: cleared by a selected load, stepped by each advance
  // beats past the fourth wrap to the loaded word again
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      beat_reg <= '0;
    end else if (sel_load) begin
      beat_reg <= '0;
    end else if (adv) begin
      beat_reg <= beat_next;
    end
  end

  // burst state: a deselect load ends the burst, pending data still completes
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      burst_live_reg <= 1'b0;
      burst_op_reg <= ZTBS_OP_IDLE;
    end else if (sel_load) begin
      burst_live_reg <= 1'b1;
      burst_op_reg <= load_op;
    end else if (desel_load) begin
      burst_live_reg <= 1'b0;
      burst_op_reg <= ZTBS_OP_IDLE;
    end
  end

  // command stage: what the data cycle after this edge will do
  // a disabled edge takes no branch, so the pending transfer simply waits
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pend_op_reg <= ZTBS_OP_IDLE;
    end else if (sel_load) begin
      pend_op_reg <= load_op;
    end else if (adv) begin
      pend_op_reg <= burst_op_reg;
    end else if (enable) begin
      pend_op_reg <= ZTBS_OP_IDLE;
    end
  end

  // data-cycle address: the loaded word, then the counter's word on each beat
  // the high address bits never move during a burst
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pend_addr_reg <= '0;
    end else if (sel_load) begin
      pend_addr_reg <= pin_if.word_address;
    end else if (adv) begin
      pend_addr_reg <= {base_reg[ADDR_W-1:ZTBS_BURST_W], low_next};
    end
  end

  // lane enables ride along with their command; reads store nothing
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pend_lane_n_reg <= '1;
    end else if (sel_load) begin
      pend_lane_n_reg <= pin_if.read_not_write ? '1 : pin_if.byte_lane_write_n;
    end else if (adv) begin
      pend_lane_n_reg <= (burst_op_reg == ZTBS_OP_WRITE) ? pin_if.byte_lane_write_n : '1;
    end
  end

  // data register stage: lanes stored at the edge closing the data cycle
  // a read loaded right behind a write to the same word sees the new value,
  // since the store lands on the very edge that opens the read's data cycle
  always_ff @(posedge clk_sys_in) begin
    if (store_en) begin
      for (int i = 0; i < LANES; i++) begin
        if (!pend_lane_n_reg[i]) begin
          array_mem[pend_addr_reg][i*LANE_W +: LANE_W] <= wr_word[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // flow-through: array feeds the pins with no register; frozen while disabled
  assign rd_word = array_mem[pend_addr_reg];
  assign pin_if.mem_data_out = rd_word;
  // output_drive_n gates only the enable, so the word itself keeps flowing
  // output enable is purely combinational; writes and deselects float
  assign pin_if.mem_data_oe = read_pend & drive_ok;
endmodule
`default_nettype wire

/* File: ztbs_ctl.sv */
// ztbs_ctl: controller end that issues single or four-beat accesses.
// assumes the sram answers one cycle after each command.
`timescale 1ns/1ps
`default_nettype none
module ztbs_ctl
  import ztbs_pkg::*;
#(
  parameter int ADDR_W = ZTBS_ADDR_W,
  parameter int DATA_W = ZTBS_DATA_W
) (
  input wire logic clk_sys_in, // controller clock
  input wire logic sys_rst_in, // async reset, high
  input wire logic clk_en_in, // freezes controller when low
  input wire logic req_valid_in, // command present
  input wire logic req_load_in, // 1 load new address, 0 advance burst
  input wire logic req_read_in, // 1 read, 0 write
  input wire logic req_deselect_in, // load as deselect cycle
  input wire logic [ADDR_W-1:0] req_addr_in, // word address
  input wire logic [DATA_W-1:0] req_wdata_in, // write data
  input wire logic [ZTBS_LANES-1:0] req_lane_n_in, // lane write enables, low
  input wire logic order_in, // burst order level
  output logic [DATA_W-1:0] rd_data_out, // captured read word
  output logic rd_valid_out, // read word pulse
  ztbs_if.ctl pin_if // sram pins
);
  // the pin widths are fixed by the interface
  if (ADDR_W != ZTBS_ADDR_W || DATA_W != ZTBS_DATA_W) begin : g_bad_geom
    $error("ztbs_ctl: unsupported geometry");
  end

  logic cmd_ce_n_reg;
  logic cmd_adv_reg;
  logic cmd_rnw_reg;
  logic cmd_desel_reg;
  logic cmd_sel_a_n_reg;
  logic cmd_sel_b_n_reg;
  logic cmd_sel_hi_reg;
  logic [ADDR_W-1:0] cmd_addr_reg;
  logic [ZTBS_LANES-1:0] cmd_lane_n_reg;
  logic order_reg;
  ztbs_op_type data_op_reg;
  ztbs_op_type burst_op_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] wdata_next_reg;
  logic issue;

  assign issue = clk_en_in & req_valid_in;

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cmd_ce_n_reg <= 1'b1;
      cmd_adv_reg <= 1'b0;
      cmd_rnw_reg <= 1'b1;
      cmd_desel_reg <= 1'b1;
      cmd_sel_a_n_reg <= 1'b1;
      cmd_sel_b_n_reg <= 1'b0;
      cmd_sel_hi_reg <= 1'b1;
      cmd_addr_reg <= '0;
      cmd_lane_n_reg <= '1;
      order_reg <= ZTBS_ORDER_LINEAR;
      wdata_next_reg <= '0;
    end else begin
      // a stalled controller must not repeat its last command on the pins
      cmd_ce_n_reg <= ~issue;
      if (clk_en_in) begin
        order_reg <= order_in;
      end
      if (issue) begin
        cmd_adv_reg <= ~req_load_in;
        cmd_rnw_reg <= req_read_in;
        cmd_desel_reg <= req_deselect_in;
        cmd_sel_a_n_reg <= req_deselect_in & (req_addr_in[1] == req_addr_in[0]);
        cmd_sel_b_n_reg <= req_deselect_in & (req_addr_in[1:0] == 2'h1);
        cmd_sel_hi_reg <= ~(req_deselect_in & (req_addr_in[1:0] == 2'h2));
        cmd_addr_reg <= req_addr_in;
        cmd_lane_n_reg <= req_lane_n_in;
        wdata_next_reg <= req_wdata_in;
      end
    end
  end

  // tracks what the cycle after each sram edge carries on the bus
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      data_op_reg <= ZTBS_OP_IDLE;
      burst_op_reg <= ZTBS_OP_IDLE;
      wdata_reg <= '0;
    end else if (!cmd_ce_n_reg) begin
      wdata_reg <= wdata_next_reg;
      if (!cmd_adv_reg && cmd_desel_reg) begin
        data_op_reg <= ZTBS_OP_IDLE;
        burst_op_reg <= ZTBS_OP_IDLE;
      end else if (!cmd_adv_reg) begin
        data_op_reg <= cmd_rnw_reg ? ZTBS_OP_READ : ZTBS_OP_WRITE;
        burst_op_reg <= cmd_rnw_reg ? ZTBS_OP_READ : ZTBS_OP_WRITE;
      end else begin
        data_op_reg <= burst_op_reg;
      end
    end
  end

  // read data sampled at the edge that closes its data cycle
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rd_data_out <= '0;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= ~cmd_ce_n_reg & (data_op_reg == ZTBS_OP_READ);
      if (!cmd_ce_n_reg && data_op_reg == ZTBS_OP_READ) begin
        rd_data_out <= pin_if.bus_data;
      end
    end
  end

  assign pin_if.cycle_enable_low = cmd_ce_n_reg;
  assign pin_if.advance_or_load = cmd_adv_reg;
  assign pin_if.read_not_write = cmd_rnw_reg;
  assign pin_if.word_address = cmd_addr_reg;
  assign pin_if.byte_lane_write_n = cmd_lane_n_reg;
  // a deselect drops one select, picked by the address low bits, so all three see use
  assign pin_if.select_low_a = cmd_sel_a_n_reg;
  assign pin_if.select_low_b = cmd_sel_b_n_reg;
  assign pin_if.select_high = cmd_sel_hi_reg;
  assign pin_if.output_drive_n = 1'b0; // tied low
  assign pin_if.burst_order_select = order_reg;
  assign pin_if.ctl_data_out = wdata_reg;
  assign pin_if.ctl_data_oe = (data_op_reg == ZTBS_OP_WRITE);
endmodule
`default_nettype wire

/* File: ztbs_chk.sv */
// ztbs_chk: pin-level checks between the sram port and its controller.
// assumes the controller keeps output_drive_n low; any one select may carry a deselect.
`timescale 1ns/1ps
`default_nettype none
module ztbs_chk (
  input wire logic clk, // pin clock
  input wire logic sys_rst_in, // async reset, high
  input wire logic read_not_write, // direction
  input wire logic advance_or_load, // 0 load
  input wire logic cycle_enable_low, // edge counts when low
  input wire logic select_low_a, // select, low
  input wire logic select_low_b, // select, low
  input wire logic select_high, // select, high
  input wire logic output_drive_n, // drive allowed when low
  input wire logic [35:0] mem_data_out, // sram data
  input wire logic mem_data_oe, // sram drives
  input wire logic ctl_data_oe // controller drives
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst_in);
  wire ld = !cycle_enable_low && !advance_or_load;
  wire sel = !select_low_a && !select_low_b && select_high;
  wire adv = !cycle_enable_low && advance_or_load;
  a_read_next_drive: assert property (ld && sel && read_not_write |=> mem_data_oe || output_drive_n)
    else $error("read load not answered next cycle");
  a_write_floats_bus: assert property (ld && sel && !read_not_write |=> !mem_data_oe)
    else $error("sram drives during write data cycle");
  a_write_data_next: assert property (ld && sel && !read_not_write |=> ctl_data_oe)
    else $error("write data missing next cycle");
  a_deselect_floats: assert property (ld && !sel |=> !mem_data_oe)
    else $error("sram drives after deselect");
  a_bus_single_owner: assert property (!(mem_data_oe && ctl_data_oe))
    else $error("both ends drive the data bus");
  a_frozen_outputs: assert property (cycle_enable_low |=> $stable(mem_data_oe) && (!mem_data_oe || $stable(mem_data_out)))
    else $error("outputs moved on a disabled edge");
  a_burst_beat_drive: assert property ((ld && sel && read_not_write) ##1 adv |=> mem_data_oe)
    else $error("burst read beat not driven");
  a_deselect_stops: assert property ((ld && !sel) ##1 adv |=> !mem_data_oe)
    else $error("advance after deselect drove the bus");
endmodule
`default_nettype wire

/* File: zero_turnaround_burst_sram_test.sv */
// zero_turnaround_burst_sram_test: controller and sram joined, random bursts read back.
// assumes one read word leaves the controller per read command in a live burst, in issue order.
`timescale 1ns/1ps
`default_nettype none
module zero_turnaround_burst_sram_test;
  import ztbs_pkg::*;
  typedef logic [ZTBS_DATA_W-1:0] ztbs_word_type;
  typedef logic [ZTBS_ADDR_W-1:0] ztbs_addr_type;
  logic clk_sys_in = 0, sys_rst_in = 1, clk_en_in = 1, req_valid_in = 0, req_load_in = 0;
  logic req_read_in = 0, req_deselect_in = 0, order_in = 0, rd_valid_out, b_order = 0, live = 0;
  logic [ZTBS_LANES-1:0] req_lane_n_in = '0;
  ztbs_addr_type req_addr_in = '0, base = '0, a;
  ztbs_word_type req_wdata_in = '0, rd_data_out;
  ztbs_word_type model [ztbs_addr_type];
  ztbs_word_type exp_q [$];
  int error_cnt = 0, n_tests = 0, seed = 79, cycles = 0, beat = 0;
  ztbs_if pin_if (.clk(clk_sys_in));
  ztbs_mem ztbs_mem_i (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .pin_if(pin_if));
  ztbs_ctl ztbs_ctl_i (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
    .req_valid_in(req_valid_in), .req_load_in(req_load_in), .req_read_in(req_read_in),
    .req_deselect_in(req_deselect_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
    .req_lane_n_in(req_lane_n_in), .order_in(order_in), .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out), .pin_if(pin_if));
  ztbs_chk ztbs_chk_i (.clk(pin_if.clk), .sys_rst_in(sys_rst_in), .read_not_write(pin_if.read_not_write),
    .advance_or_load(pin_if.advance_or_load), .cycle_enable_low(pin_if.cycle_enable_low),
    .select_low_a(pin_if.select_low_a), .select_low_b(pin_if.select_low_b), .select_high(pin_if.select_high),
    .output_drive_n(pin_if.output_drive_n), .mem_data_out(pin_if.mem_data_out),
    .mem_data_oe(pin_if.mem_data_oe), .ctl_data_oe(pin_if.ctl_data_oe));
  initial forever #50 clk_sys_in = ~clk_sys_in;
  function automatic ztbs_addr_type beat_addr(input ztbs_addr_type b, input logic ord, input int k);
    logic [1:0] lo;
    lo = ord ? (b[1:0] ^ k[1:0]) : (b[1:0] + k[1:0]);
    return {b[ZTBS_ADDR_W-1:2], lo};
  endfunction
  function automatic ztbs_word_type merge(input ztbs_word_type old, input ztbs_word_type d, input logic [3:0] ln);
    ztbs_word_type r;
    r = old;
    for (int i = 0; i < ZTBS_LANES; i++) if (!ln[i]) r[ZTBS_LANE_W*i +: ZTBS_LANE_W] = d[ZTBS_LANE_W*i +: ZTBS_LANE_W];
    return r;
  endfunction
  task automatic check_word(input string name, input ztbs_word_type e, input ztbs_word_type g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic check_cnt(input string name, input int e, input int g);
    n_tests++;
    if (g != e) begin
      error_cnt++;
      $display("wrong value %s expected %0d seen %0d", name, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // expectations are booked at issue time, so a read behind a write sees the new word
  task automatic issue(input logic ld, rd, ds, ord, input ztbs_addr_type ad, input ztbs_word_type d,
      input logic [3:0] ln);
    ztbs_addr_type ea;
    req_valid_in <= 1;
    req_load_in <= ld;
    req_read_in <= rd;
    req_deselect_in <= ds;
    req_addr_in <= ad;
    req_wdata_in <= d;
    req_lane_n_in <= ln;
    order_in <= ord;
    if (ld) begin
      base = ad;
      beat = 0;
      b_order = ord;
      live = !ds;
    end else beat++;
    ea = beat_addr(base, b_order, beat);
    if (live && rd) exp_q.push_back(model[ea]);
    if (live && !rd) model[ea] = merge(model.exists(ea) ? model[ea] : '0, d, ln);
    @(posedge clk_sys_in);
  endtask
  task automatic idle(input int n);
    req_valid_in <= 0;
    repeat (n) @(posedge clk_sys_in);
  endtask
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (rd_valid_out === 1'b1) begin
      if (exp_q.size() == 0) check_cnt("unexpected read word", 0, 1);
      else check_word("read word", exp_q.pop_front(), rd_data_out);
    end
    if (cycles == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    logic ord;
    repeat (16) @(posedge clk_sys_in);
    sys_rst_in <= 0;
    @(posedge clk_sys_in);
    for (int t = 0; t < 40; t++) begin
      ord = $random(seed);
      a = $random(seed);
      if (t < 2) a[1:0] = 2'h3;
      for (int k = 0; k < 4; k++) issue(k == 0, 0, 0, ord, a, $random(seed), 4'h0);
      issue(1, 0, 0, ord, beat_addr(a, ord, t % 4), {$random(seed), $random(seed)}, $random(seed));
      for (int k = 0; k < 4; k++) issue(k == 0, 1, 0, ord, a, $random(seed), $random(seed));
      if (t % 4 == 1) begin
        issue(1, 0, 1, ord, a, '0, 4'h0);
        issue(0, 1, 0, ord, a, '0, 4'h0);
      end
      if (t % 5 == 2) begin
        idle(4);
        clk_en_in <= 0;
        repeat (1 + ({$random(seed)} % 4)) @(posedge clk_sys_in);
        clk_en_in <= 1;
      end
    end
    issue(1, 0, 1, 0, '0, '0, 4'hf); // a counted edge closes the last read's data cycle
    idle(8);
    check_cnt("words still pending", 0, exp_q.size());
    report_and_stop();
  end
endmodule
`default_nettype wire
